// ===== shared/itl_pkg.sv
// Constants and state encodings for the instrument bus talker/listener.
package itl_pkg;

  // Bus address: factory value and the highest address the device accepts.
  localparam logic [4:0] ADDR_DEFAULT = 5'h0b;
  localparam logic [4:0] ADDR_MAX     = 5'h1e;

  // Command groups in bits 6:5 of a command byte, and the two unaddress commands.
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;
  localparam logic [6:0] CMD_UNL    = 7'h3f;
  localparam logic [6:0] CMD_UNT    = 7'h5f;

  // Receive buffer depth in characters, and its index width.
  localparam logic [6:0] BUF_DEPTH = 7'h64;
  localparam logic [6:0] IDX_ZERO  = 7'h00;
  localparam logic [6:0] IDX_ONE   = 7'h01;

  // Bit positions of the synchronised management and handshake lines.
  localparam int CTL_ATN  = 0;
  localparam int CTL_REN  = 1;
  localparam int CTL_IFC  = 2;
  localparam int CTL_DAV  = 3;
  localparam int CTL_NRFD = 4;
  localparam int CTL_NDAC = 5;
  localparam int CTL_EOI  = 6;

  // Data settling time before the talker asserts data valid.
  localparam int         CLK_NS      = 40;
  localparam int         SETTLE_NS   = 2000;
  localparam logic [5:0] SETTLE_CYC  = 6'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_CYC - 6'h01);

  // Acceptor handshake states.
  typedef enum logic [2:0] {
    ACC_IDLE  = 3'h1,
    ACC_READY = 3'h2,
    ACC_DONE  = 3'h4
  } itl_acc_type;

  // Source handshake states.
  typedef enum logic [2:0] {
    SRC_IDLE   = 3'h1,
    SRC_SETTLE = 3'h2,
    SRC_WAIT   = 3'h4
  } itl_src_type;

endpackage

// ===== rtl/itl_core.sv
// Talker/listener interface logic for a parallel instrument bus.
// Operation
// - Talker or listener, never both, no controller.
// - Manual talk-only mode; no listen-only mode.
// - Eight-bit bytes under three-wire handshake.
// - Attention true: bytes are bus commands.
// - Attention false: bytes are device data.
// - Service request drives its line low.
// - Interface clear drops talker and listener; in talk-only mode the talker role stays.
// - End line marks last byte; poll.
// - Handshake paces transfers to slowest party.
// - One address, 0 to 30, default 11.
// - Buffer 100 characters, hold off beyond.
module itl_core (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       atn_n,
  input  wire logic       ren_n,
  input  wire logic       ifc_n,
  input  wire logic       dav_n,
  input  wire logic       nrfd_n,
  input  wire logic       ndac_n,
  input  wire logic       eoi_n,
  input  wire logic [7:0] dio_n,
  output logic      [7:0] dio_o,
  output logic      [7:0] dio_oe,
  output logic            dav_o,
  output logic            dav_oe,
  output logic            nrfd_o,
  output logic            nrfd_oe,
  output logic            ndac_o,
  output logic            ndac_oe,
  output logic            eoi_o,
  output logic            eoi_oe,
  output logic            srq_o,
  output logic            srq_oe,
  input  wire logic       talk_only,
  input  wire logic       service_request,
  input  wire logic       poll_enable,
  input  wire logic [2:0] poll_line,
  input  wire logic [4:0] addr_in,
  input  wire logic       addr_load,
  output logic      [4:0] bus_addr,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_end,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_end,
  output logic            rx_valid,
  input  wire logic       rx_take,
  output logic            talking,
  output logic            listening,
  output logic            remote
);

  typedef struct packed {
    logic [7:0]                                s1_dio;
    logic [7:0]                                s2_dio;
    logic [6:0]                                s1_ctl;
    logic [6:0]                                s2_ctl;
    logic [4:0]                                addr;
    logic                                      talking;
    logic                                      listening;
    logic                                      remote;
    itl_pkg::itl_acc_type                      acc;
    itl_pkg::itl_src_type                      src;
    logic [5:0]                                settle;
    logic [itl_pkg::BUF_DEPTH-1:0][8:0]        mem;
    logic [6:0]                                head;
    logic [6:0]                                tail;
    logic [6:0]                                cnt;
    logic [8:0]                                rx_word;
    logic                                      rx_valid;
    logic [7:0]                                dio_drv;
    logic                                      dav_drv;
    logic                                      nrfd_drv;
    logic                                      ndac_drv;
    logic                                      eoi_drv;
    logic                                      srq_drv;
    logic                                      low_level;
    logic                                      tx_ready;
  } itl_state_type;

  itl_state_type q;
  itl_state_type next_q;
  logic          push;
  logic          pop;
  logic          cmd_take;
  logic          atn_t;
  logic          eoi_t;
  logic          dav_t;
  logic          engaged;
  logic          room;
  logic [6:0]    cmd;

  // Advances a buffer index with wrap at the buffer depth.
  function automatic logic [6:0] itl_next_idx(input logic [6:0] idx);
    return (idx == itl_pkg::BUF_DEPTH - itl_pkg::IDX_ONE) ? itl_pkg::IDX_ZERO
                                                           : idx + itl_pkg::IDX_ONE;
  endfunction

  // True levels of the synchronised lines.
  assign atn_t   = q.s2_ctl[itl_pkg::CTL_ATN];
  assign eoi_t   = q.s2_ctl[itl_pkg::CTL_EOI];
  assign dav_t   = q.s2_ctl[itl_pkg::CTL_DAV];
  assign engaged = atn_t || q.listening;
  assign room    = q.cnt < itl_pkg::BUF_DEPTH;
  assign cmd     = q.s2_dio[6:0];

  // Next-state logic for the whole port.
  always_comb begin
    next_q   = q;
    push     = 1'b0;
    pop      = 1'b0;
    cmd_take = 1'b0;
    // Bus pins are active low and asynchronous, so each passes two flip-flops.
    next_q.s1_dio = ~dio_n;
    next_q.s2_dio = q.s1_dio;
    next_q.s1_ctl = ~{eoi_n, ndac_n, nrfd_n, dav_n, ifc_n, ren_n, atn_n};
    next_q.s2_ctl = q.s1_ctl;
    next_q.srq_drv = service_request;
    if (addr_load && addr_in <= itl_pkg::ADDR_MAX) begin
      next_q.addr = addr_in;
    end

    // Acceptor: takes part in every command byte, and in data bytes while listening.
    unique case (q.acc)
      itl_pkg::ACC_IDLE: begin
        next_q.nrfd_drv = 1'b0;
        next_q.ndac_drv = 1'b0;
        if (engaged) begin
          next_q.ndac_drv = 1'b1;
          next_q.nrfd_drv = 1'b1;
          next_q.acc      = itl_pkg::ACC_READY;
        end
      end
      itl_pkg::ACC_READY: begin
        next_q.ndac_drv = 1'b1;
        next_q.nrfd_drv = !(atn_t || room);
        if (!engaged) begin
          next_q.acc = itl_pkg::ACC_IDLE;
        end else if (dav_t && !q.nrfd_drv) begin
          cmd_take        = atn_t;
          push            = !atn_t;
          next_q.nrfd_drv = 1'b1;
          next_q.ndac_drv = 1'b0;
          next_q.acc      = itl_pkg::ACC_DONE;
        end
      end
      itl_pkg::ACC_DONE: begin
        if (!dav_t) begin
          next_q.ndac_drv = 1'b1;
          next_q.acc      = itl_pkg::ACC_READY;
        end
      end
      default: begin
        next_q.acc = itl_pkg::ACC_IDLE;
      end
    endcase

    // Address commands: listen and talk addresses unaddress the other role.
    if (cmd_take) begin
      if (cmd == {itl_pkg::GRP_LISTEN, q.addr}) begin
        next_q.listening = 1'b1;
        next_q.talking   = 1'b0;
        next_q.remote    = q.s2_ctl[itl_pkg::CTL_REN];
      end else if (cmd == {itl_pkg::GRP_TALK, q.addr}) begin
        next_q.talking   = 1'b1;
        next_q.listening = 1'b0;
      end else if (cmd == itl_pkg::CMD_UNL) begin
        next_q.listening = 1'b0;
      end else if (cmd[6:5] == itl_pkg::GRP_TALK) begin
        next_q.talking = 1'b0;
      end
    end
    if (!q.s2_ctl[itl_pkg::CTL_REN]) begin
      next_q.remote = 1'b0;
    end
    if (q.s2_ctl[itl_pkg::CTL_IFC]) begin
      next_q.talking   = 1'b0;
      next_q.listening = 1'b0;
    end
    if (talk_only) begin
      next_q.talking   = 1'b1;
      next_q.listening = 1'b0;
    end

    // Receive buffer: push a data byte with its end flag, pop on user take.
    pop = rx_take && q.rx_valid;
    if (push) begin
      next_q.mem[q.tail] = {eoi_t, q.s2_dio};
      next_q.tail        = itl_next_idx(q.tail);
    end
    if (pop) begin
      next_q.head = itl_next_idx(q.head);
    end
    next_q.cnt = q.cnt + (push ? itl_pkg::IDX_ONE : itl_pkg::IDX_ZERO)
                       - (pop ? itl_pkg::IDX_ONE : itl_pkg::IDX_ZERO);

    // Source: settle data, assert valid, hold until all listeners accept.
    unique case (q.src)
      itl_pkg::SRC_IDLE: begin
        if (tx_valid && q.tx_ready) begin
          next_q.dio_drv = tx_data;
          next_q.eoi_drv = tx_end;
          next_q.settle  = 6'h00;
          next_q.src     = itl_pkg::SRC_SETTLE;
        end
      end
      itl_pkg::SRC_SETTLE: begin
        if (q.settle < itl_pkg::SETTLE_LAST) begin
          next_q.settle = q.settle + 6'h01;
        end else if (!q.s2_ctl[itl_pkg::CTL_NRFD] && q.s2_ctl[itl_pkg::CTL_NDAC]) begin
          next_q.dav_drv = 1'b1;
          next_q.src     = itl_pkg::SRC_WAIT;
        end
      end
      itl_pkg::SRC_WAIT: begin
        if (!q.s2_ctl[itl_pkg::CTL_NDAC]) begin
          next_q.dav_drv = 1'b0;
          next_q.dio_drv = 8'h00;
          next_q.eoi_drv = 1'b0;
          next_q.src     = itl_pkg::SRC_IDLE;
        end
      end
      default: begin
        next_q.src = itl_pkg::SRC_IDLE;
      end
    endcase
    if (atn_t || !q.talking) begin
      next_q.dav_drv = 1'b0;
      next_q.dio_drv = 8'h00;
      next_q.eoi_drv = 1'b0;
      next_q.src     = itl_pkg::SRC_IDLE;
    end
    // Parallel poll: attention with end line makes the device show its status bit.
    if (next_q.src == itl_pkg::SRC_IDLE && atn_t) begin
      next_q.dio_drv = (eoi_t && poll_enable && service_request) ?
                       8'(8'h01 << poll_line) : 8'h00;
    end
    next_q.tx_ready = next_q.src == itl_pkg::SRC_IDLE && next_q.talking && !atn_t;
    next_q.rx_word  = next_q.mem[next_q.head];
    next_q.rx_valid = next_q.cnt != itl_pkg::IDX_ZERO;
  end

  // State register with asynchronous reset.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q      <= '0;
      q.addr <= itl_pkg::ADDR_DEFAULT;
      q.acc  <= itl_pkg::ACC_IDLE;
      q.src  <= itl_pkg::SRC_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // Outputs come straight from the state register; pins only ever pull low.
  assign dio_o     = {8{q.low_level}};
  assign dio_oe    = q.dio_drv;
  assign dav_o     = q.low_level;
  assign dav_oe    = q.dav_drv;
  assign nrfd_o    = q.low_level;
  assign nrfd_oe   = q.nrfd_drv;
  assign ndac_o    = q.low_level;
  assign ndac_oe   = q.ndac_drv;
  assign eoi_o     = q.low_level;
  assign eoi_oe    = q.eoi_drv;
  assign srq_o     = q.low_level;
  assign srq_oe    = q.srq_drv;
  assign bus_addr  = q.addr;
  assign tx_ready  = q.tx_ready;
  assign rx_data   = q.rx_word[7:0];
  assign rx_end    = q.rx_word[8];
  assign rx_valid  = q.rx_valid;
  assign talking   = q.talking;
  assign listening = q.listening;
  assign remote    = q.remote;

  // Checks on roles, handshake and buffer limits.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_one_role;
    !(q.talking && q.listening);
  endproperty
  a_one_role: assert property (p_one_role) else $error("talker and listener at once");

  property p_talk_only;
    talk_only |=> q.talking && !q.listening;
  endproperty
  a_talk_only: assert property (p_talk_only) else $error("talk-only not honoured");

  property p_data_stable;
    q.dav_drv |-> $stable(q.dio_drv) && $stable(q.eoi_drv);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved under valid");

  property p_mla;
    cmd_take && !talk_only && !q.s2_ctl[itl_pkg::CTL_IFC]
      && cmd == {itl_pkg::GRP_LISTEN, q.addr} |=> q.listening && !q.talking;
  endproperty
  a_mla: assert property (p_mla) else $error("listen address ignored");

  property p_data_mode;
    push |-> !atn_t && q.listening && q.cnt < itl_pkg::BUF_DEPTH;
  endproperty
  a_data_mode: assert property (p_data_mode) else $error("data byte taken in command mode");

  property p_srq;
    $rose(service_request) |=> q.srq_drv ##1 (q.srq_drv || !$past(service_request));
  endproperty
  a_srq: assert property (p_srq) else $error("service request not driven");

  property p_ifc;
    q.s2_ctl[itl_pkg::CTL_IFC] && !talk_only |=> !q.talking && !q.listening ##1 !q.dav_drv;
  endproperty
  a_ifc: assert property (p_ifc) else $error("interface clear ignored");

  property p_poll;
    atn_t && eoi_t && poll_enable && service_request |=> q.dio_drv != 8'h00;
  endproperty
  a_poll: assert property (p_poll) else $error("no parallel poll response");

  property p_hold_valid;
    q.dav_drv && q.s2_ctl[itl_pkg::CTL_NDAC] && !atn_t && q.talking |=> q.dav_drv;
  endproperty
  a_hold_valid: assert property (p_hold_valid) else $error("valid dropped early");

  property p_addr;
    q.addr <= itl_pkg::ADDR_MAX;
  endproperty
  a_addr: assert property (p_addr) else $error("address out of range");

  property p_full;
    q.cnt == itl_pkg::BUF_DEPTH && q.listening && !atn_t && q.acc == itl_pkg::ACC_READY
      |=> q.nrfd_drv;
  endproperty
  a_full: assert property (p_full) else $error("full buffer not holding off");

  c_talk: cover property (q.src == itl_pkg::SRC_WAIT ##[1:50] q.src == itl_pkg::SRC_IDLE);
  c_listen: cover property (push && eoi_t);
  c_full: cover property (q.cnt == itl_pkg::BUF_DEPTH);
  c_poll: cover property (atn_t && eoi_t && q.dio_drv != 8'h00);

endmodule

// ===== sim/itl_ctrl_model.sv
// Bus controller model that commands the device and plays talker or listener.
module itl_ctrl_model (
  input  wire logic       clock,
  input  wire logic       dav_n,
  input  wire logic       nrfd_n,
  input  wire logic       ndac_n,
  input  wire logic       eoi_n,
  input  wire logic [7:0] dio_n,
  output logic            atn,
  output logic            ren,
  output logic            ifc,
  output logic            eoi,
  output logic            dav,
  output logic            nrfd,
  output logic            ndac,
  output logic      [7:0] dio
);
  timeunit 1ns;
  timeprecision 1ps;
  int lag;

  // Every pull starts released; a high output pulls its bus line low.
  initial begin
    {atn, ren, ifc, eoi, dav, nrfd, ndac, dio} = 15'h0000;
    lag = 0;
  end

  // Source handshake: wait for readiness, settle the byte, hold it until accepted.
  task automatic send(input logic [7:0] b, input logic e, output logic ok);
    int n;
    ok = 1'b0;
    // A listener must be present (data not accepted held low) and ready before the byte goes out.
    for (n = 0; n < 100 && !(nrfd_n === 1'b1 && ndac_n === 1'b0); n++) begin
      @(posedge clock);
      #2;
    end
    if (!(nrfd_n === 1'b1 && ndac_n === 1'b0)) return;
    dio = b;
    eoi = e;
    repeat (2 + lag) @(posedge clock);
    #2 dav = 1'b1;
    for (n = 0; n < 100 && ndac_n !== 1'b1; n++) begin
      @(posedge clock);
      #2;
    end
    ok = ndac_n;
    @(posedge clock);
    #2 {dav, eoi, dio} = 10'h000;
  endtask

  // Sends one byte in command mode and leaves command mode afterwards.
  task automatic cmd(input logic [7:0] c);
    logic ok;
    atn = 1'b1;
    send(c, 1'b0, ok);
    @(posedge clock);
    #2 atn = 1'b0;
  endtask

  // Acceptor handshake: get ready, take the byte on data valid, then accept it.
  task automatic recv(output logic [7:0] b, output logic e, output logic ok);
    int n;
    ndac = 1'b1;
    nrfd = 1'b1;
    @(posedge clock);
    #2;
    repeat (lag) begin
      @(posedge clock);
      #2;
    end
    nrfd = 1'b0;
    for (n = 0; n < 300 && dav_n !== 1'b0; n++) begin
      @(posedge clock);
      #2;
    end
    b = ~dio_n;
    e = ~eoi_n;
    ok = ~dav_n;
    @(posedge clock);
    #2 nrfd = 1'b1;
    ndac = 1'b0;
    for (n = 0; n < 300 && dav_n !== 1'b1; n++) begin
      @(posedge clock);
      #2;
    end
    @(posedge clock);
    #2 {nrfd, ndac} = 2'h0;
  endtask
endmodule

// ===== sim/tb_instrument_bus_talker_listener.sv
// Self-checking bench: device core against a bus controller model and a reference queue.
module tb_instrument_bus_talker_listener;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock, sys_rst, talk_only, service_request, poll_enable, addr_load;
  logic       tx_end, tx_valid, tx_ready, rx_take, rx_end, rx_valid, ok, e;
  logic       talking, listening, remote, srq_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe;
  logic [2:0] poll_line;
  logic [4:0] addr_in, adr, bus_addr;
  logic [7:0] tx_data, rx_data, dio_oe, b;
  logic [8:0] q[$];
  logic [8:0] tq[4];
  wire logic  atn_n, ren_n, ifc_n, dav_n, nrfd_n, ndac_n, eoi_n;
  wire logic  m_atn, m_ren, m_ifc, m_eoi, m_dav, m_nrfd, m_ndac;
  wire logic [7:0] dio_n, m_dio;
  int         err_total, checks_done, k, cnt;

  itl_core i_itl_core (
    .clock, .sys_rst, .atn_n, .ren_n, .ifc_n, .dav_n, .nrfd_n, .ndac_n, .eoi_n, .dio_n,
    .dio_o(), .dio_oe, .dav_o(), .dav_oe, .nrfd_o(), .nrfd_oe, .ndac_o(), .ndac_oe,
    .eoi_o(), .eoi_oe, .srq_o(), .srq_oe, .talk_only, .service_request, .poll_enable,
    .poll_line, .addr_in, .addr_load, .bus_addr, .tx_data, .tx_end, .tx_valid, .tx_ready,
    .rx_data, .rx_end, .rx_valid, .rx_take, .talking, .listening, .remote
  );

  // The only controller on the bus, so it is always the active one.
  itl_ctrl_model i_itl_ctrl_model (
    .clock, .dav_n, .nrfd_n, .ndac_n, .eoi_n, .dio_n, .atn(m_atn), .ren(m_ren),
    .ifc(m_ifc), .eoi(m_eoi), .dav(m_dav), .nrfd(m_nrfd), .ndac(m_ndac), .dio(m_dio)
  );

  // Open-drain bus: a line is low while any party pulls it, else the pull-up wins.
  assign atn_n  = ~m_atn;
  assign ren_n  = ~m_ren;
  assign ifc_n  = ~m_ifc;
  assign dav_n  = ~(m_dav | dav_oe);
  assign nrfd_n = ~(m_nrfd | nrfd_oe);
  assign ndac_n = ~(m_ndac | ndac_oe);
  assign eoi_n  = ~(m_eoi | eoi_oe);
  assign dio_n  = ~(m_dio | dio_oe);

  // The clock toggles every half period of 20 ns.
  initial clock = 1'b0;
  always #20 clock = ~clock;

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits a number of edges and lands just after the last one.
  task automatic step(input int c);
    repeat (c) @(posedge clock);
    #2;
  endtask

  // Presents an address on the load strobe for one edge.
  task automatic load_addr(input logic [4:0] a);
    addr_in = a;
    addr_load = 1'b1;
    step(1);
    addr_load = 1'b0;
    step(1);
  endtask

  // Sends one data byte from the controller and records what the device should hold.
  task automatic send_data(input logic [7:0] d, input logic last);
    i_itl_ctrl_model.send(d, last, ok);
    chk("sent", 1'b1, ok);
    q.push_back({last, d});
  endtask

  // Pops the receive buffer and compares every entry with the reference queue.
  task automatic drain();
    logic [8:0] x;
    for (int i = 0; i < 2000 && q.size() > 0; i++) begin
      if (rx_valid === 1'b1) begin
        x = q.pop_front();
        chk("rx_data", x[7:0], rx_data);
        chk("rx_end", x[8], rx_end);
        rx_take = 1'b1;
        step(1);
        rx_take = 1'b0;
      end
      step(1);
    end
    chk("rx_valid", 1'b0, rx_valid);
  endtask

  // Offers one byte to the talker and holds it until the edge that takes it.
  task automatic put(input logic [8:0] x);
    step(1);
    {tx_end, tx_data} = x;
    tx_valid = 1'b1;
    for (int i = 0; i < 300 && tx_ready !== 1'b1; i++) step(1);
    step(1);
    tx_valid = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #800000;
    err_total++;
    results();
  end

  // Main sequence of scenarios.
  initial begin
    void'($urandom(32'h05cfa646));
    {talk_only, service_request, poll_enable, addr_load, tx_end, tx_valid, rx_take} = 7'h00;
    {poll_line, addr_in, tx_data} = 16'h0000;
    sys_rst = 1'b1;
    repeat (20) @(posedge clock);
    #2 sys_rst = 1'b0;
    step(3);
    chk("bus_addr", itl_pkg::ADDR_DEFAULT, bus_addr);
    chk("roles", 3'h0, {talking, listening, remote});
    // An out-of-range address is ignored, the top and a random one are taken.
    load_addr(5'h1f);
    chk("bus_addr", itl_pkg::ADDR_DEFAULT, bus_addr);
    load_addr(itl_pkg::ADDR_MAX);
    chk("bus_addr", itl_pkg::ADDR_MAX, bus_addr);
    adr = 5'($urandom % 31);
    load_addr(adr);
    chk("bus_addr", adr, bus_addr);
    // Remote enable first, then the listen address in command mode.
    i_itl_ctrl_model.ren = 1'b1;
    i_itl_ctrl_model.cmd({3'h1, adr});
    chk("roles", 3'h6, {listening, remote, talking});
    // A talk address sent as data must land in the buffer, not change roles.
    send_data({3'h2, adr}, 1'b0);
    cnt = 1 + $urandom % 8;
    for (k = 0; k < cnt; k++) send_data(8'($urandom), k == cnt - 1);
    chk("talking", 1'b0, talking);
    drain();
    // Fill the buffer; the next byte must be held off.
    for (k = 0; k < 100; k++) send_data(8'($urandom), 1'b0);
    i_itl_ctrl_model.send(8'h55, 1'b0, ok);
    chk("held_off", 1'b0, ok);
    drain();
    // Talk addressing drops listening; bytes go out to a slow or prompt listener.
    i_itl_ctrl_model.cmd({3'h2, adr});
    chk("roles", 2'h1, {listening, talking});
    for (k = 0; k < 4; k++) tq[k] = {k == 3, 8'($urandom)};
    fork
      for (int j = 0; j < 4; j++) put(tq[j]);
      for (int j = 0; j < 4; j++) begin
        i_itl_ctrl_model.lag = $urandom % 20;
        i_itl_ctrl_model.recv(b, e, ok);
        chk("tx_byte", {1'b1, tq[j]}, {ok, e, b});
      end
    join
    // Interface clear drops the talker and listener roles; remote stays set.
    i_itl_ctrl_model.ifc = 1'b1;
    step(4);
    chk("roles", 2'h0, {listening, talking});
    i_itl_ctrl_model.ifc = 1'b0;
    // Service request, then a parallel poll answered on the configured line.
    service_request = 1'b1;
    step(2);
    chk("srq_oe", 1'b1, srq_oe);
    poll_enable = 1'b1;
    poll_line = 3'($urandom % 8);
    i_itl_ctrl_model.atn = 1'b1;
    i_itl_ctrl_model.eoi = 1'b1;
    step(6);
    chk("poll", 8'h01 << poll_line, dio_oe);
    i_itl_ctrl_model.atn = 1'b0;
    i_itl_ctrl_model.eoi = 1'b0;
    service_request = 1'b0;
    step(3);
    chk("srq_oe", 1'b0, srq_oe);
    // Talk-only forces the talker role and refuses listening.
    talk_only = 1'b1;
    step(4);
    i_itl_ctrl_model.cmd({3'h1, adr});
    chk("roles", 2'h1, {listening, talking});
    results();
  end
endmodule
